/* hw/ipc_pkg.sv */
`default_nettype none
package ipc_pkg;

    localparam logic [3:0] ipc_addr_status = 4'h0;
    localparam logic [3:0] ipc_addr_control = 4'h1;
    localparam logic [3:0] ipc_addr_ictl1 = 4'h2;
    localparam logic [3:0] ipc_addr_enable1 = 4'h3;
    localparam logic [3:0] ipc_addr_prio2 = 4'h4;
    localparam logic [3:0] ipc_addr_prio7 = 4'h5;
    localparam logic [3:0] ipc_addr_prio8 = 4'h6;
    localparam logic [3:0] ipc_addr_evstat = 4'h7;
    localparam logic [3:0] ipc_addr_evmask = 4'h8;

    localparam int ipc_level_lsb = 5;
    localparam int ipc_high_bit_pos = 3;
    localparam int ipc_nest_dis_pos = 15;
    localparam int ipc_sources = 10;
    localparam logic [2:0] ipc_prio_reset = 3'h4;
    localparam logic [15:0] ipc_status_mask = 16'h00e0;
    localparam logic [15:0] ipc_prio_mask = 16'h7777;
    localparam logic [15:0] ipc_prio8_mask = 16'h0077;
    localparam logic [15:0] ipc_enable1_mask = 16'h0003;
    localparam logic [15:0] ipc_prio_rst_word = 16'h4444;
    localparam logic [15:0] ipc_prio8_rst_word = 16'h0044;

    typedef struct packed {
        logic [2:0] level;
        logic high_bit;
        logic nest_dis;
        logic [1:0] enable;
        logic [15:0] prio2;
        logic [15:0] prio7;
        logic [15:0] prio8;
        logic [1:0] evstat;
        logic [1:0] evmask;
        logic [31:0] rdata;
        logic waitreq;
        logic [3:0] eff_level;
        logic [ipc_sources-1:0] req;
        logic [3:0] req_prio;
        logic irq;
    } ipc_state_t;

endpackage : ipc_pkg
`default_nettype wire

/* hw/ipc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ipc_top #(
    parameter int sources = ipc_pkg::ipc_sources
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Peripheral requests: 0 uart1 rx, 1 spi1, 2 spi1 fault, 3 timer3, 4 uart2 tx,
    // 5 uart2 rx, 6 ext2, 7 timer5, 8 spi2, 9 spi2 fault
    input wire logic [sources-1:0] src_pending,
    // I2C1 requests: bit 1 master event, bit 0 slave event
    input wire logic [1:0] i2c1_pending,
    // CPU side
    input wire logic cpu_take,
    input wire logic [3:0] cpu_take_level,
    output logic [sources-1:0] cpu_request,
    output logic [3:0] cpu_request_prio,
    output logic [3:0] cpu_level,
    output logic irq
);

    ipc_pkg::ipc_state_t s_q;
    ipc_pkg::ipc_state_t s_d;
    logic [2:0] prio [sources];
    logic [1:0] i2c_ev;
    logic [15:0] rd16;

    ////////////////////////////////////////////////////////////////////////
    // Per-source priority field view

    always_comb begin
        prio[0] = s_q.prio2[14:12];
        prio[1] = s_q.prio2[10:8];
        prio[2] = s_q.prio2[6:4];
        prio[3] = s_q.prio2[2:0];
        prio[4] = s_q.prio7[14:12];
        prio[5] = s_q.prio7[10:8];
        prio[6] = s_q.prio7[6:4];
        prio[7] = s_q.prio7[2:0];
        prio[8] = s_q.prio8[6:4];
        prio[9] = s_q.prio8[2:0];
    end

    assign i2c_ev = i2c1_pending & s_q.enable;

    always_comb begin
        if (avs_address == ipc_pkg::ipc_addr_status) begin
            rd16 = {8'h00, s_q.level, 5'h00};
        end else if (avs_address == ipc_pkg::ipc_addr_control) begin
            rd16 = {12'h000, s_q.high_bit, 3'h0};
        end else if (avs_address == ipc_pkg::ipc_addr_ictl1) begin
            rd16 = {s_q.nest_dis, 15'h0000};
        end else if (avs_address == ipc_pkg::ipc_addr_enable1) begin
            rd16 = {14'h0000, s_q.enable};
        end else if (avs_address == ipc_pkg::ipc_addr_prio2) begin
            rd16 = s_q.prio2;
        end else if (avs_address == ipc_pkg::ipc_addr_prio7) begin
            rd16 = s_q.prio7;
        end else if (avs_address == ipc_pkg::ipc_addr_prio8) begin
            rd16 = s_q.prio8;
        end else if (avs_address == ipc_pkg::ipc_addr_evstat) begin
            rd16 = {14'h0000, s_q.evstat};
        end else if (avs_address == ipc_pkg::ipc_addr_evmask) begin
            rd16 = {14'h0000, s_q.evmask};
        end else begin
            // Unmapped words read zero
            rd16 = 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic wr;
        logic rd;
        logic [3:0] best;
        wr = 1'b0;
        rd = 1'b0;
        best = 4'h0;
        s_d = s_q;
        // One wait cycle on every access so read data comes from a register
        s_d.waitreq = 1'b1;
        if ((avs_read || avs_write) && s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            wr = avs_write;
            rd = avs_read;
            s_d.rdata = {16'h0000, rd16};
        end
        // CPU acknowledge raises the level; a bus write in the same cycle loses
        if (cpu_take) begin
            s_d.level = cpu_take_level[2:0];
            s_d.high_bit = cpu_take_level[3];
        end
        if (wr) begin
            if (avs_address == ipc_pkg::ipc_addr_status && !s_q.nest_dis && !cpu_take) begin
                s_d.level = avs_writedata[ipc_pkg::ipc_level_lsb +: 3];
            end
            if (avs_address == ipc_pkg::ipc_addr_control && !cpu_take) begin
                s_d.high_bit = s_q.high_bit & avs_writedata[ipc_pkg::ipc_high_bit_pos];
            end
            if (avs_address == ipc_pkg::ipc_addr_ictl1) begin
                s_d.nest_dis = avs_writedata[ipc_pkg::ipc_nest_dis_pos];
            end
            if (avs_address == ipc_pkg::ipc_addr_enable1) begin
                s_d.enable = avs_writedata[1:0];
            end
            if (avs_address == ipc_pkg::ipc_addr_prio2) begin
                s_d.prio2 = avs_writedata[15:0] & ipc_pkg::ipc_prio_mask;
            end
            if (avs_address == ipc_pkg::ipc_addr_prio7) begin
                s_d.prio7 = avs_writedata[15:0] & ipc_pkg::ipc_prio_mask;
            end
            if (avs_address == ipc_pkg::ipc_addr_prio8) begin
                s_d.prio8 = avs_writedata[15:0] & ipc_pkg::ipc_prio8_mask;
            end
            if (avs_address == ipc_pkg::ipc_addr_evmask) begin
                s_d.evmask = avs_writedata[1:0];
            end
        end
        // Read clears status; a new event in the same cycle still sets
        if (rd && avs_address == ipc_pkg::ipc_addr_evstat) begin
            s_d.evstat = 2'b00;
        end
        s_d.evstat = s_d.evstat | i2c_ev;
        s_d.eff_level = {s_d.high_bit, s_d.level};
        s_d.req = '0;
        for (int i = 0; i < sources; i++) begin
            // Zero priority never wins since zero is never above any level
            if (src_pending[i] && ({1'b0, prio[i]} > s_q.eff_level)) begin
                s_d.req[i] = 1'b1;
                if ({1'b0, prio[i]} > best) begin
                    best = {1'b0, prio[i]};
                end
            end
        end
        s_d.req_prio = best;
        s_d.irq = |(s_d.evstat & s_q.evmask);
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.waitreq <= 1'b1;
            s_q.prio2 <= ipc_pkg::ipc_prio_rst_word;
            s_q.prio7 <= ipc_pkg::ipc_prio_rst_word;
            s_q.prio8 <= ipc_pkg::ipc_prio8_rst_word;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all registered

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign cpu_request = s_q.req;
    assign cpu_request_prio = s_q.req_prio;
    assign cpu_level = s_q.eff_level;
    assign irq = s_q.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence ctl_write_clear;
        avs_write && s_q.waitreq && avs_address == ipc_pkg::ipc_addr_control && !cpu_take;
    endsequence

    chk_level_locked: assert property (@(posedge clock) disable iff (reset)
        (s_q.nest_dis && !cpu_take) |=> $stable(s_q.level))
        else $error("level changed while nesting disabled");
    chk_high_never_set: assert property (@(posedge clock) disable iff (reset)
        (!s_q.high_bit && !cpu_take) |=> !s_q.high_bit)
        else $error("high level bit set by software");
    chk_high_clear: assert property (@(posedge clock) disable iff (reset)
        (ctl_write_clear and !avs_writedata[3]) |=> !s_q.high_bit)
        else $error("high level bit not cleared");
    chk_eff_level: assert property (@(posedge clock) disable iff (reset)
        cpu_level == {s_q.high_bit, s_q.level})
        else $error("effective level mismatch");
    chk_req_above: assert property (@(posedge clock) disable iff (reset)
        cpu_request[0] |-> ({1'b0, $past(prio[0])} > $past(s_q.eff_level)))
        else $error("request at or below cpu level");
    chk_zero_disabled: assert property (@(posedge clock) disable iff (reset)
        (prio[3] == 3'h0) |=> !cpu_request[3])
        else $error("disabled source requested");
    chk_unimpl_zero: assert property (@(posedge clock) disable iff (reset)
        (s_q.prio2 & ~ipc_pkg::ipc_prio_mask) == 16'h0000)
        else $error("unimplemented bit set");
    chk_i2c_mask: assert property (@(posedge clock) disable iff (reset)
        (i2c1_pending[1] && s_q.enable[1]) |=> s_q.evstat[1])
        else $error("enabled i2c event lost");
    chk_status_field: assert property (@(posedge clock) disable iff (reset)
        (avs_read && !s_q.waitreq) |-> ((avs_address != ipc_pkg::ipc_addr_status)
        || ((avs_readdata[15:0] & ~ipc_pkg::ipc_status_mask) == 16'h0000)))
        else $error("status read shows bits outside level field");

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake, register write and register read checks

    sequence bus_accept;
        (avs_read || avs_write) && s_q.waitreq;
    endsequence

    sequence read_done;
        avs_read && !s_q.waitreq;
    endsequence

    sequence status_write;
        avs_write && s_q.waitreq && avs_address == ipc_pkg::ipc_addr_status
            && !s_q.nest_dis && !cpu_take;
    endsequence

    sequence ictl_write;
        avs_write && s_q.waitreq && avs_address == ipc_pkg::ipc_addr_ictl1;
    endsequence

    sequence enable_write;
        avs_write && s_q.waitreq && avs_address == ipc_pkg::ipc_addr_enable1;
    endsequence

    sequence prio2_write;
        avs_write && s_q.waitreq && avs_address == ipc_pkg::ipc_addr_prio2;
    endsequence

    sequence prio8_write;
        avs_write && s_q.waitreq && avs_address == ipc_pkg::ipc_addr_prio8;
    endsequence

    sequence evstat_read_clear;
        avs_read && s_q.waitreq && avs_address == ipc_pkg::ipc_addr_evstat
            && i2c_ev == 2'b00;
    endsequence

    chk_wait_one: assert property (@(posedge clock) disable iff (reset)
        bus_accept |=> !avs_waitrequest)
        else $error("access not answered after one wait cycle");
    chk_wait_single: assert property (@(posedge clock) disable iff (reset)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_wait_idle: assert property (@(posedge clock) disable iff (reset)
        (!avs_read && !avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without an access");
    chk_rdata_hold: assert property (@(posedge clock) disable iff (reset)
        (!avs_read && !avs_write) |=> $stable(avs_readdata))
        else $error("read data changed while idle");
    chk_rdata_upper: assert property (@(posedge clock) disable iff (reset)
        avs_readdata[31:16] == 16'h0000)
        else $error("upper read data half not zero");

    chk_level_write: assert property (@(posedge clock) disable iff (reset)
        status_write |=> ({24'h000000, s_q.level, 5'h00}
        == ($past(avs_writedata) & {16'h0000, ipc_pkg::ipc_status_mask})))
        else $error("level field write lost");
    chk_level_hold: assert property (@(posedge clock) disable iff (reset)
        (!cpu_take && !(avs_write && s_q.waitreq)) |=> $stable(s_q.level))
        else $error("level changed with no write or take");
    chk_take_level: assert property (@(posedge clock) disable iff (reset)
        cpu_take |=> (cpu_level == $past(cpu_take_level)))
        else $error("taken level not loaded");
    chk_high_on_take: assert property (@(posedge clock) disable iff (reset)
        (cpu_take && cpu_take_level[3]) |=> s_q.high_bit)
        else $error("high level bit not set on take");
    chk_nest_write: assert property (@(posedge clock) disable iff (reset)
        ictl_write |=> (s_q.nest_dis == $past(avs_writedata[ipc_pkg::ipc_nest_dis_pos])))
        else $error("nesting disable write lost");
    chk_nest_hold: assert property (@(posedge clock) disable iff (reset)
        !(avs_write && s_q.waitreq && avs_address == ipc_pkg::ipc_addr_ictl1)
        |=> $stable(s_q.nest_dis))
        else $error("nesting disable changed without a write");
    chk_enable_write: assert property (@(posedge clock) disable iff (reset)
        enable_write |=> (s_q.enable == $past(avs_writedata[1:0])))
        else $error("enable write lost");
    chk_prio2_write: assert property (@(posedge clock) disable iff (reset)
        prio2_write |=> (s_q.prio2 == ($past(avs_writedata[15:0]) & ipc_pkg::ipc_prio_mask)))
        else $error("priority register 2 write lost");
    chk_prio8_write: assert property (@(posedge clock) disable iff (reset)
        prio8_write |=> (s_q.prio8 == ($past(avs_writedata[15:0]) & ipc_pkg::ipc_prio8_mask)))
        else $error("priority register 8 write lost");
    chk_prio_hold: assert property (@(posedge clock) disable iff (reset)
        !(avs_write && s_q.waitreq)
        |=> ($stable(s_q.prio2) && $stable(s_q.prio7) && $stable(s_q.prio8)))
        else $error("priority field changed without a write");
    chk_unimpl_prio7: assert property (@(posedge clock) disable iff (reset)
        (s_q.prio7 & ~ipc_pkg::ipc_prio_mask) == 16'h0000)
        else $error("unimplemented bit set in priority register 7");
    chk_unimpl_prio8: assert property (@(posedge clock) disable iff (reset)
        (s_q.prio8 & ~ipc_pkg::ipc_prio8_mask) == 16'h0000)
        else $error("unimplemented bit set in priority register 8");

    chk_control_read: assert property (@(posedge clock) disable iff (reset)
        (read_done and (avs_address == ipc_pkg::ipc_addr_control))
        |-> ((avs_readdata & ~32'h00000008) == 32'h00000000))
        else $error("control read shows bits beside the high level bit");
    chk_ictl_read: assert property (@(posedge clock) disable iff (reset)
        (read_done and (avs_address == ipc_pkg::ipc_addr_ictl1))
        |-> (avs_readdata[14:0] == 15'h0000))
        else $error("control 1 read shows unimplemented bits");
    chk_enable_read: assert property (@(posedge clock) disable iff (reset)
        (read_done and (avs_address == ipc_pkg::ipc_addr_enable1))
        |-> (avs_readdata[15:2] == 14'h0000))
        else $error("enable read shows unimplemented bits");
    chk_unmapped_read: assert property (@(posedge clock) disable iff (reset)
        (read_done and (avs_address > ipc_pkg::ipc_addr_evmask))
        |-> (avs_readdata == 32'h00000000))
        else $error("unmapped word read not zero");

    ////////////////////////////////////////////////////////////////////////
    // Request and event checks

    chk_req_pending: assert property (@(posedge clock) disable iff (reset)
        (cpu_request & ~$past(src_pending)) == '0)
        else $error("request without a pending source");
    chk_req_prio_zero: assert property (@(posedge clock) disable iff (reset)
        (cpu_request == '0) |-> (cpu_request_prio == 4'h0))
        else $error("request priority shown with no request");
    chk_req_prio_above: assert property (@(posedge clock) disable iff (reset)
        (cpu_request != '0) |-> (cpu_request_prio > $past(cpu_level)))
        else $error("request priority not above cpu level");
    chk_slave_event: assert property (@(posedge clock) disable iff (reset)
        (i2c1_pending[0] && s_q.enable[0]) |=> s_q.evstat[0])
        else $error("enabled slave event lost");
    chk_masked_event: assert property (@(posedge clock) disable iff (reset)
        (!s_q.evstat[0] && !(i2c1_pending[0] && s_q.enable[0])) |=> !s_q.evstat[0])
        else $error("masked slave event latched");
    chk_evstat_clear: assert property (@(posedge clock) disable iff (reset)
        evstat_read_clear |=> (s_q.evstat == 2'b00))
        else $error("event status not cleared by read");
    chk_irq_level: assert property (@(posedge clock) disable iff (reset)
        irq == |(s_q.evstat & $past(s_q.evmask)))
        else $error("interrupt output does not follow masked status");

    // Per-source view of the ranking rule
    for (genvar g = 0; g < sources; g++) begin : gen_src_chk
        chk_src_above: assert property (@(posedge clock) disable iff (reset)
            cpu_request[g] |-> ({1'b0, $past(prio[g])} > $past(cpu_level)))
            else $error("source request at or below cpu level");
        chk_src_taken: assert property (@(posedge clock) disable iff (reset)
            (src_pending[g] && ({1'b0, prio[g]} > cpu_level)) |=> cpu_request[g])
            else $error("eligible source not requested");
    end

endmodule : ipc_top
`default_nettype wire

/* tb/ipc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ipc_cpu_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Bench commands
    input wire logic auto_take,
    input wire logic force_take,
    input wire logic [3:0] force_level,
    // Controller side
    input wire logic [3:0] cpu_request_prio,
    output logic cpu_take,
    output logic [3:0] cpu_take_level
);
    // Taking a request raises the level to its priority; the gap stops back-to-back takes, yet the same request is taken again two cycles later
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cpu_take <= 1'b0;
            cpu_take_level <= 4'h0;
        end else begin
            cpu_take <= force_take || (auto_take && cpu_request_prio != 4'h0 && !cpu_take);
            cpu_take_level <= force_take ? force_level : cpu_request_prio;
        end
    end
endmodule : ipc_cpu_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0] avs_address = 4'h0, cpu_request_prio, cpu_level, take_level;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [9:0] src_pending = 10'h0, cpu_request;
    logic [1:0] i2c1_pending = 2'h0;
    logic cpu_take, irq, auto_take = 1'b0, force_take = 1'b0;
    logic [3:0] force_level = 4'h0;
    logic [15:0] q;
    int fails = 0, n_tests = 0;
    // Rows: write flag, address, write data, expected read back
    localparam logic [36:0] rows [15] = '{
        {1'b0, 4'h0, 16'h0, 16'h0000}, {1'b0, 4'h1, 16'h0, 16'h0000},
        {1'b0, 4'h3, 16'h0, 16'h0000}, {1'b0, 4'h4, 16'h0, 16'h4444},
        {1'b0, 4'h5, 16'h0, 16'h4444}, {1'b0, 4'h6, 16'h0, 16'h0044},
        {1'b0, 4'hf, 16'h0, 16'h0000}, {1'b1, 4'h4, 16'hffff, 16'h7777},
        {1'b1, 4'h5, 16'hffff, 16'h7777}, {1'b1, 4'h6, 16'hffff, 16'h0077},
        {1'b1, 4'h3, 16'hffff, 16'h0003}, {1'b1, 4'h0, 16'hffff, 16'h00e0},
        {1'b1, 4'h1, 16'h0008, 16'h0000}, {1'b1, 4'hf, 16'hffff, 16'h0000},
        {1'b1, 4'h8, 16'h0002, 16'h0002}};
    ipc_top i_ipc_top (.clock(clock), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .src_pending(src_pending), .i2c1_pending(i2c1_pending), .cpu_take(cpu_take),
        .cpu_take_level(take_level), .cpu_request(cpu_request),
        .cpu_request_prio(cpu_request_prio), .cpu_level(cpu_level), .irq(irq));
    ipc_cpu_model i_ipc_cpu_model (.clock(clock), .reset(reset), .auto_take(auto_take),
        .force_take(force_take), .force_level(force_level),
        .cpu_request_prio(cpu_request_prio), .cpu_take(cpu_take), .cpu_take_level(take_level));
    always #4 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (e !== g) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Holds the request until waitrequest is sampled low, then releases it
    task automatic rw(input logic w, input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'h0, d};
        do @(posedge clock); while (avs_waitrequest !== 1'b0 && ++n < 50);
        if (n >= 50) chk("waitrequest", 16'h0, 16'h1);
        q = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : rw
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        rw(1'b0, a, 16'h0);
        chk("readdata", e, q);
    endtask : rd
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(8 * 20000);
        fails++;
        give_verdict();
    end
    initial begin
        tick(20);
        chk("reset level", 16'h0, {12'h0, cpu_level});
        reset <= 1'b0;
        for (int i = 0; i < 15; i++) begin
            if (rows[i][36]) rw(1'b1, rows[i][35:32], rows[i][31:16]);
            rd(rows[i][35:32], rows[i][15:0]);
        end
        $display("test register table done");
        rw(1'b1, 4'h2, 16'hffff);
        rd(4'h2, 16'h8000);
        rw(1'b1, 4'h0, 16'h0000);
        rd(4'h0, 16'h00e0);
        rw(1'b1, 4'h2, 16'h0000);
        rw(1'b1, 4'h0, 16'h0040);
        rd(4'h0, 16'h0040);
        $display("test nesting disable done");
        force_level <= 4'hb;
        force_take <= 1'b1;
        tick(1);
        force_take <= 1'b0;
        tick(3);
        chk("cpu_level", 16'h000b, {12'h0, cpu_level});
        rd(4'h1, 16'h0008);
        rd(4'h0, 16'h0060);
        rw(1'b1, 4'h1, 16'h0000);
        rd(4'h1, 16'h0000);
        chk("cpu_level", 16'h0003, {12'h0, cpu_level});
        $display("test high bit done");
        rw(1'b1, 4'h4, 16'h4031);
        src_pending <= 10'h00f;
        tick(3);
        chk("cpu_request", 16'h0001, {6'h0, cpu_request});
        chk("cpu_request_prio", 16'h0004, {12'h0, cpu_request_prio});
        rw(1'b1, 4'h0, 16'h0000);
        tick(3);
        chk("cpu_request", 16'h000d, {6'h0, cpu_request});
        auto_take <= 1'b1;
        tick(8);
        chk("cpu_level", 16'h0004, {12'h0, cpu_level});
        chk("cpu_request", 16'h0000, {6'h0, cpu_request});
        auto_take <= 1'b0;
        src_pending <= 10'h0;
        $display("test request ranking done");
        i2c1_pending <= 2'b01;
        tick(3);
        chk("irq masked", 16'h0, {15'h0, irq});
        i2c1_pending <= 2'b00;
        rd(4'h7, 16'h0001);
        rd(4'h7, 16'h0000);
        i2c1_pending <= 2'b10;
        tick(3);
        chk("irq", 16'h1, {15'h0, irq});
        i2c1_pending <= 2'b00;
        rd(4'h7, 16'h0002);
        tick(2);
        chk("irq cleared", 16'h0, {15'h0, irq});
        rw(1'b1, 4'h3, 16'h0001);
        i2c1_pending <= 2'b10;
        tick(3);
        i2c1_pending <= 2'b00;
        rd(4'h7, 16'h0000);
        $display("test events done");
        reset <= 1'b1;
        tick(2);
        reset <= 1'b0;
        chk("cpu_level", 16'h0, {12'h0, cpu_level});
        rd(4'h4, 16'h4444);
        $display("test second reset done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
